// ===== pwm_cmp_pkg.sv
// Package: register map, field layout, reset values and states for the PWM compare block
`default_nettype none
package pwm_cmp_pkg;
    // Word offsets of the registers, byte addresses
    localparam logic [5:0] OFS_CYCLE     = 6'h00;
    localparam logic [5:0] OFS_DUTY_U    = 6'h04;
    localparam logic [5:0] OFS_DUTY_V    = 6'h08;
    localparam logic [5:0] OFS_DUTY_W    = 6'h0C;
    localparam logic [5:0] OFS_CULL_OPT  = 6'h10;
    localparam logic [5:0] OFS_ADC_A     = 6'h14;
    localparam logic [5:0] OFS_ADC_B     = 6'h18;
    localparam logic [5:0] OFS_MODE      = 6'h1C;
    localparam logic [5:0] OFS_STATUS    = 6'h20;
    // Cull option field layout
    localparam int CULL_CNT_LSB = 0;
    localparam int CULL_CNT_MSB = 4;
    localparam int CREST_EN_BIT = 5;
    localparam int VALLEY_EN_BIT = 6;
    // Mode register field layout
    localparam int ANYTIME_BIT  = 0;
    localparam int XFER_CULL_BIT = 1;
    localparam int RUN_BIT      = 2;
    // Reset values
    localparam logic [15:0] CYCLE_RST = 16'hFFFF;
    localparam logic [15:0] DUTY_RST  = 16'h0000;
    localparam logic [15:0] ADC_RST   = 16'h0000;
    localparam logic [6:0]  OPT_RST   = 7'h60;
    localparam logic [2:0]  MODE_RST  = 3'h0;
    // Counter points
    localparam logic [15:0] VALLEY_VAL = 16'h0001;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [4:0]  CULL_ZERO  = 5'h00;
    // Count direction, Gray along up -> down
    typedef enum logic [0:0] {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_e;
endpackage
`default_nettype wire

// ===== pwm_compare_buffer_transfer.sv
// Buffered compare update logic of a triangular three-phase PWM timer
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`default_nettype none
module pwm_compare_buffer_transfer (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Classic Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Phase outputs
    output logic      [2:0]  phase_top_out_o,
    output logic      [2:0]  phase_bottom_out_o,
    // Events
    output logic             crest_irq_o,
    output logic             valley_irq_o,
    output logic      [2:0]  duty_match_irq_o,
    output logic      [1:0]  adc_trigger_o,
    output logic             transfer_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
        logic [15:0] r;
        r = old_v;
        if (sel[0]) r[7:0]  = wd[7:0];
        if (sel[1]) r[15:8] = wd[15:8];
        return r;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] cyc_reg_q, cyc_reg_d, cyc_buf_q, cyc_buf_d;
    logic [15:0] duty_reg_q [3], duty_reg_d [3];
    logic [15:0] duty_buf_q [3], duty_buf_d [3];
    logic [15:0] adc_reg_q [2], adc_reg_d [2];
    logic [15:0] adc_buf_q [2], adc_buf_d [2];
    logic [6:0]  opt_reg_q, opt_reg_d, opt_buf_q, opt_buf_d;
    logic [2:0]  mode_q, mode_d;
    logic        armed_q, armed_d;
    logic [15:0] cnt_q, cnt_d;
    pwm_cmp_pkg::dir_e dir_q, dir_d;
    logic [4:0]  cull_q, cull_d;
    logic [2:0]  matched_q, matched_d;
    logic [2:0]  top_q, top_d, bot_q, bot_d;
    logic [31:0] rdat_q, rdat_d;
    logic        ack_q, ack_d;
    logic        crest_q, crest_d, valley_q, valley_d, xfer_q, xfer_d;
    logic [2:0]  dirq_q, dirq_d;
    logic [1:0]  adcq_q, adcq_d;

    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    logic wr, rd_req, anytime, xfer_cull, running;
    logic crest_pt, valley_pt, issue, cull_done;
    logic crest_iss, valley_iss, xfer_now;
    logic [2:0] duty_hit;
    logic [1:0] adc_hit;

    // Bus strobes and mode bits; ack gap keeps one access per request
    assign wr       = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
    assign rd_req   = wb_cyc_i & wb_stb_i & ~ack_q;
    assign anytime  = mode_q[pwm_cmp_pkg::ANYTIME_BIT];
    assign xfer_cull = mode_q[pwm_cmp_pkg::XFER_CULL_BIT];
    assign running  = mode_q[pwm_cmp_pkg::RUN_BIT];
    // Cycle match only counted while counting up
    assign crest_pt  = running & (dir_q == pwm_cmp_pkg::DIR_UP)
                       & (cnt_q == cyc_buf_q);
    assign valley_pt = running & (dir_q == pwm_cmp_pkg::DIR_DOWN)
                       & (cnt_q == pwm_cmp_pkg::VALLEY_VAL);
    // Culling: mask cull-count occurrences, issue the next
    assign cull_done = (cull_q == opt_buf_q[pwm_cmp_pkg::CULL_CNT_MSB:
                                            pwm_cmp_pkg::CULL_CNT_LSB]);
    assign crest_iss  = crest_pt & opt_buf_q[pwm_cmp_pkg::CREST_EN_BIT]
                        & cull_done;
    assign valley_iss = valley_pt & opt_buf_q[pwm_cmp_pkg::VALLEY_EN_BIT]
                        & cull_done;
    assign issue = crest_iss | valley_iss;
    // Transfer moment depends on mode
    assign xfer_now = ~anytime & armed_q &
                      (xfer_cull ? issue
                                 : (crest_pt | valley_pt));

    // ------------------------------------------------------------
    // Register file and buffer next state
    // ------------------------------------------------------------
    always_comb begin
        cyc_reg_d = cyc_reg_q;
        opt_reg_d = opt_reg_q;
        mode_d    = mode_q;
        armed_d   = armed_q;
        cyc_buf_d = cyc_buf_q;
        opt_buf_d = opt_buf_q;
        for (int i = 0; i < 3; i++) begin
            duty_reg_d[i] = duty_reg_q[i];
            duty_buf_d[i] = duty_buf_q[i];
        end
        for (int i = 0; i < 2; i++) begin
            adc_reg_d[i] = adc_reg_q[i];
            adc_buf_d[i] = adc_buf_q[i];
        end
        if (wr) begin
            if (wb_adr_i == pwm_cmp_pkg::OFS_CYCLE) begin
                cyc_reg_d = merge16(cyc_reg_q, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_DUTY_U) begin
                duty_reg_d[0] = merge16(duty_reg_q[0], wb_dat_i, wb_sel_i);
                armed_d = 1'b1;
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_DUTY_V) begin
                duty_reg_d[1] = merge16(duty_reg_q[1], wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_DUTY_W) begin
                duty_reg_d[2] = merge16(duty_reg_q[2], wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_CULL_OPT) begin
                if (wb_sel_i[0]) opt_reg_d = wb_dat_i[6:0];
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_ADC_A) begin
                adc_reg_d[0] = merge16(adc_reg_q[0], wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_ADC_B) begin
                adc_reg_d[1] = merge16(adc_reg_q[1], wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_MODE) begin
                if (wb_sel_i[0]) mode_d = wb_dat_i[2:0];
            end
        end
        if (anytime) begin
            // Each buffer follows its register at once
            cyc_buf_d = cyc_reg_d;
            opt_buf_d = opt_reg_d;
            for (int i = 0; i < 3; i++) duty_buf_d[i] = duty_reg_d[i];
            for (int i = 0; i < 2; i++) adc_buf_d[i] = adc_reg_d[i];
            armed_d = 1'b0;
        end else if (xfer_now) begin
            // Whole set moves at once, ADC compares included
            cyc_buf_d = cyc_reg_q;
            opt_buf_d = opt_reg_q;
            for (int i = 0; i < 3; i++) duty_buf_d[i] = duty_reg_q[i];
            for (int i = 0; i < 2; i++) adc_buf_d[i] = adc_reg_q[i];
            // A duty U write in the transfer cycle arms again: set wins
            armed_d = wr && (wb_adr_i == pwm_cmp_pkg::OFS_DUTY_U);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cyc_reg_q <= pwm_cmp_pkg::CYCLE_RST;
            cyc_buf_q <= pwm_cmp_pkg::CYCLE_RST;
            opt_reg_q <= pwm_cmp_pkg::OPT_RST;
            opt_buf_q <= pwm_cmp_pkg::OPT_RST;
            mode_q    <= pwm_cmp_pkg::MODE_RST;
            armed_q   <= 1'b0;
            for (int i = 0; i < 3; i++) begin
                duty_reg_q[i] <= pwm_cmp_pkg::DUTY_RST;
                duty_buf_q[i] <= pwm_cmp_pkg::DUTY_RST;
            end
            for (int i = 0; i < 2; i++) begin
                adc_reg_q[i] <= pwm_cmp_pkg::ADC_RST;
                adc_buf_q[i] <= pwm_cmp_pkg::ADC_RST;
            end
        end else begin
            cyc_reg_q <= cyc_reg_d;
            cyc_buf_q <= cyc_buf_d;
            opt_reg_q <= opt_reg_d;
            opt_buf_q <= opt_buf_d;
            mode_q    <= mode_d;
            armed_q   <= armed_d;
            duty_reg_q <= duty_reg_d;
            duty_buf_q <= duty_buf_d;
            adc_reg_q <= adc_reg_d;
            adc_buf_q <= adc_buf_d;
        end
    end

    // ------------------------------------------------------------
    // Counter, culling, match and outputs
    // ------------------------------------------------------------
    always_comb begin
        cnt_d     = cnt_q;
        dir_d     = dir_q;
        cull_d    = cull_q;
        matched_d = matched_q;
        top_d     = top_q;
        crest_d   = crest_iss;
        valley_d  = valley_iss;
        xfer_d    = xfer_now | (anytime & wr);
        duty_hit  = 3'h0;
        adc_hit   = 2'h0;
        for (int i = 0; i < 3; i++) begin
            duty_hit[i] = running & (cnt_q == duty_buf_q[i]);
        end
        for (int i = 0; i < 2; i++) begin
            adc_hit[i] = running & (cnt_q == adc_buf_q[i]);
        end
        dirq_d = duty_hit;
        adcq_d = adc_hit;
        if (running) begin
            // Wraps past FFFF when cycle was set below count
            if (crest_pt) begin
                dir_d = pwm_cmp_pkg::DIR_DOWN;
                cnt_d = cnt_q - 16'h0001;
            end else if (valley_pt) begin
                dir_d = pwm_cmp_pkg::DIR_UP;
                cnt_d = cnt_q - 16'h0001;
            end else if (dir_q == pwm_cmp_pkg::DIR_UP) begin
                cnt_d = cnt_q + 16'h0001;
            end else begin
                cnt_d = cnt_q - 16'h0001;
            end
            if (crest_pt | valley_pt) begin
                matched_d = 3'h0;
                cull_d = cull_done ? pwm_cmp_pkg::CULL_ZERO
                                   : cull_q + 5'h01;
            end
            // Forced edges first, a genuine match overrides them
            for (int i = 0; i < 3; i++) begin
                if (crest_iss) top_d[i] = 1'b1;
                if (valley_iss) top_d[i] = 1'b0;
                if (duty_hit[i] & ~matched_q[i]) begin
                    // Live buffer compare: fresh value acts now; a
                    // match at a turning point counts for the new slope
                    top_d[i] = (dir_d == pwm_cmp_pkg::DIR_UP);
                    matched_d[i] = ~(crest_pt | valley_pt);
                end
            end
        end
        if (wr && wb_adr_i == pwm_cmp_pkg::OFS_CULL_OPT) begin
            cull_d = pwm_cmp_pkg::CULL_ZERO;
        end
        // Bottom leg registered too, so both legs switch on one edge
        bot_d = ~top_d;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q     <= pwm_cmp_pkg::COUNT_ZERO;
            dir_q     <= pwm_cmp_pkg::DIR_UP;
            cull_q    <= pwm_cmp_pkg::CULL_ZERO;
            matched_q <= 3'h0;
            top_q     <= 3'h0;
            bot_q     <= 3'h7;
            crest_q   <= 1'b0;
            valley_q  <= 1'b0;
            xfer_q    <= 1'b0;
            dirq_q    <= 3'h0;
            adcq_q    <= 2'h0;
        end else begin
            cnt_q     <= cnt_d;
            dir_q     <= dir_d;
            cull_q    <= cull_d;
            matched_q <= matched_d;
            top_q     <= top_d;
            bot_q     <= bot_d;
            crest_q   <= crest_d;
            valley_q  <= valley_d;
            xfer_q    <= xfer_d;
            dirq_q    <= dirq_d;
            adcq_q    <= adcq_d;
        end
    end

    // ------------------------------------------------------------
    // Wishbone read and ack, registered: one wait state
    // ------------------------------------------------------------
    always_comb begin
        ack_d  = rd_req;
        rdat_d = 32'h0000_0000;
        if (rd_req & ~wb_we_i) begin
            if (wb_adr_i == pwm_cmp_pkg::OFS_CYCLE) begin
                rdat_d = {16'h0000, cyc_reg_q};
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_DUTY_U) begin
                rdat_d = {16'h0000, duty_reg_q[0]};
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_DUTY_V) begin
                rdat_d = {16'h0000, duty_reg_q[1]};
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_DUTY_W) begin
                rdat_d = {16'h0000, duty_reg_q[2]};
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_CULL_OPT) begin
                rdat_d = {25'h0000000, opt_reg_q};
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_ADC_A) begin
                rdat_d = {16'h0000, adc_reg_q[0]};
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_ADC_B) begin
                rdat_d = {16'h0000, adc_reg_q[1]};
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_MODE) begin
                rdat_d = {29'h00000000, mode_q};
            end else if (wb_adr_i == pwm_cmp_pkg::OFS_STATUS) begin
                rdat_d = {cnt_q, 9'h000, cull_q, dir_q, armed_q};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // Outputs straight from flip-flops
    assign wb_ack_o           = ack_q;
    assign wb_dat_o           = rdat_q;
    assign phase_top_out_o    = top_q;
    assign phase_bottom_out_o = bot_q;
    assign crest_irq_o        = crest_q;
    assign valley_irq_o       = valley_q;
    assign duty_match_irq_o   = dirq_q;
    assign adc_trigger_o      = adcq_q;
    assign transfer_o         = xfer_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_arm;
        ~anytime & wr & (wb_adr_i == pwm_cmp_pkg::OFS_DUTY_U);
    endsequence

    a_arm_duty_u: assert property (@(posedge clk_i) disable iff (rst_i)
        s_arm |=> armed_q)
        else $error("duty U write did not arm");
    a_xfer_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        xfer_now & ~wr |=> ~armed_q)
        else $error("armed stayed after transfer");
    a_xfer_copy: assert property (@(posedge clk_i) disable iff (rst_i)
        xfer_now & ~anytime |=> adc_buf_q[0] == $past(adc_reg_q[0])
                                && cyc_buf_q == $past(cyc_reg_q))
        else $error("set not copied at transfer");
    a_no_arm_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ~anytime & ~armed_q & ~$past(anytime) |=> $stable(duty_buf_q[1]))
        else $error("buffer changed without arming");
    a_anytime_now: assert property (@(posedge clk_i) disable iff (rst_i)
        anytime & wr & (wb_adr_i == pwm_cmp_pkg::OFS_CYCLE) & (&wb_sel_i[1:0])
        |=> cyc_buf_q == $past(wb_dat_i[15:0]))
        else $error("anytime write not immediate");
    a_crest_force: assert property (@(posedge clk_i) disable iff (rst_i)
        crest_iss & ~(|duty_hit) |=> &top_q)
        else $error("crest did not force high");
    a_valley_force: assert property (@(posedge clk_i) disable iff (rst_i)
        valley_iss & ~(|duty_hit) |=> top_q == 3'h0)
        else $error("valley did not force low");
    a_crest_off: assert property (@(posedge clk_i) disable iff (rst_i)
        ~opt_buf_q[pwm_cmp_pkg::CREST_EN_BIT] |=> ~crest_irq_o)
        else $error("crest issued while disabled");
    a_cull_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        wr & (wb_adr_i == pwm_cmp_pkg::OFS_CULL_OPT) |=> cull_q == 5'h00)
        else $error("cull counter not cleared");
    a_ignore_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        duty_hit[0] & matched_q[0] & ~crest_iss & ~valley_iss
        |=> $stable(top_q[0]) && duty_match_irq_o[0])
        else $error("ignored match changed output");
    a_down_no_crest: assert property (@(posedge clk_i) disable iff (rst_i)
        dir_q == pwm_cmp_pkg::DIR_DOWN & cnt_q != pwm_cmp_pkg::VALLEY_VAL
        |=> dir_q == pwm_cmp_pkg::DIR_DOWN)
        else $error("cycle match while down");

endmodule
`default_nettype wire

// ===== gate_drive_model.sv
// Far-side gate driver model: watches the six phase lines for shoot-through
`default_nettype none
module gate_drive_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Phase lines from the timer
    input  wire logic [2:0] top_i,
    input  wire logic [2:0] bot_i,
    // Sticky fault seen by the bench
    output var  logic       bad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // A leg with both switches on would short the supply rail
    always @(posedge clk_i) begin
        if (rst_i) begin
            bad_o <= 1'b0;
        end else if (bot_i !== ~top_i) begin
            bad_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== pwm_compare_buffer_transfer_tb_top.sv
// Self-checking bench of the buffered compare transfer block
`default_nettype none
module pwm_compare_buffer_transfer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals, event counters and model
    // ----------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [5:0]  wb_adr = 6'h00;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h00000000;
    logic [31:0] rdat;
    logic        ack;
    logic [2:0]  top;
    logic [2:0]  bot;
    logic [2:0]  dmi;
    logic [1:0]  adc;
    logic        crest;
    logic        valley;
    logic        xfer;
    logic        bad;
    logic [31:0] seed = 32'h7EBDB22C;
    logic [31:0] mdl [0:8] = '{32'h0000FFFF, 0, 0, 0, 32'h60, 0, 0, 0, 0};
    int num_errors = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    int t_xf = 0;
    int t_irq = 0;
    int t_cr = 0;
    int n_cr = 0;
    int n_va = 0;
    int n_irq = 0;
    int n_xf = 0;
    int n_adc = 0;
    int n_dm = 0;

    always #4 clk_i = ~clk_i;

    pwm_compare_buffer_transfer pwm_compare_buffer_transfer_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .phase_top_out_o(top), .phase_bottom_out_o(bot),
        .crest_irq_o(crest), .valley_irq_o(valley),
        .duty_match_irq_o(dmi), .adc_trigger_o(adc), .transfer_o(xfer));

    gate_drive_model gate_drive_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .top_i(top), .bot_i(bot), .bad_o(bad));

    // Event log; counts are read as snapshots, so windows need no loops
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (crest === 1'b1) begin
            n_cr <= n_cr + 1;
            t_cr <= cyc_n;
        end
        if (valley === 1'b1) n_va <= n_va + 1;
        if ((crest | valley) === 1'b1) begin
            n_irq <= n_irq + 1;
            t_irq <= cyc_n;
        end
        if (xfer === 1'b1) begin
            n_xf <= n_xf + 1;
            t_xf <= cyc_n;
        end
        if (adc[0] === 1'b1) n_adc <= n_adc + 1;
        if (dmi[0] === 1'b1) n_dm <= n_dm + 1;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic finish_test();
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic cycle; entered right after a rising edge
    task automatic bus(input logic [5:0] a, input logic w,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= 4'h3;
        wb_wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50) num_errors++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
        mdl[a >> 2] = d & ((a == pwm_cmp_pkg::OFS_CULL_OPT) ? 32'h7F :
                           (a == pwm_cmp_pkg::OFS_MODE) ? 32'h7 : 32'hFFFF);
    endtask

    task automatic rd(input logic [5:0] a, output logic [31:0] q);
        bus(a, 1'b0, 32'h0, q);
    endtask

    function automatic int ev(input int k);
        case (k)
            0: return n_cr;
            1: return n_va;
            2: return n_irq;
            default: return n_xf;
        endcase
    endfunction

    // Bounded wait for the next event of one kind
    task automatic wait_ev(input int k);
        int b;
        int n;
        b = ev(k);
        n = 0;
        while (ev(k) == b && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 2000) num_errors++;
    endtask

    // Crest to crest span, with trigger and match pulses inside it
    task automatic period(output int p, output int na, output int nd);
        int a;
        wait_ev(0);
        a = t_cr;
        na = n_adc;
        nd = n_dm;
        wait_ev(0);
        p = t_cr - a;
        na = n_adc - na;
        nd = n_dm - nd;
    endtask

    // Fixed window; a length of k periods holds exactly k periodic events
    task automatic win(input int len, output int c, output int v,
                       output int i);
        c = n_cr;
        v = n_va;
        i = n_irq;
        repeat (len) @(posedge clk_i);
        c = n_cr - c;
        v = n_va - v;
        i = n_irq - i;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] q;
        int p1;
        int p2;
        int a;
        int b;
        int c;
        int d;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            rd(6'(i * 4), q);
            chk32(q, mdl[i]);
        end
        rd(6'h24, q);
        chk32(q, 32'h0);
        for (int i = 5; i < 7; i++) begin
            wr(6'(i * 4), xs());
            rd(6'(i * 4), q);
            chk32(q, mdl[i]);
        end
        // Anytime writes reach the buffer at once
        wr(pwm_cmp_pkg::OFS_MODE, 32'h1);
        wr(pwm_cmp_pkg::OFS_CYCLE, 32'h20);
        chk_n(int'(cyc_n - t_xf <= 4), 1);
        wr(pwm_cmp_pkg::OFS_DUTY_U, 32'h8);
        wr(pwm_cmp_pkg::OFS_ADC_A, 32'h5);
        wr(pwm_cmp_pkg::OFS_MODE, 32'h5);
        period(p1, a, b);
        // Batch: writes without duty U leave the buffers alone
        wr(pwm_cmp_pkg::OFS_MODE, 32'h4);
        wr(pwm_cmp_pkg::OFS_CYCLE, 32'h30);
        wr(pwm_cmp_pkg::OFS_ADC_A, 32'h40);
        rd(pwm_cmp_pkg::OFS_STATUS, q);
        chk32({31'h0, q[0]}, 32'h0);
        period(p2, a, b);
        chk_n(p2, p1);
        chk_n(a, 2);
        wait_ev(0);
        wr(pwm_cmp_pkg::OFS_DUTY_U, 32'h8);
        rd(pwm_cmp_pkg::OFS_STATUS, q);
        chk32({31'h0, q[0]}, 32'h1);
        wait_ev(3);
        rd(pwm_cmp_pkg::OFS_STATUS, q);
        chk32({31'h0, q[0]}, 32'h0);
        period(p2, a, b);
        chk_n(p2, p1 + 2 * (32'h30 - 32'h20));
        chk_n(a, 0);
        chk_n(b, 2);
        wait_ev(0);
        repeat (3) @(posedge clk_i);
        chk32({31'h0, top[0]}, 32'h1);
        wait_ev(1);
        repeat (3) @(posedge clk_i);
        chk32({31'h0, top[0]}, 32'h0);
        repeat (12) @(posedge clk_i);
        chk32({31'h0, top[0]}, 32'h1);
        // Interrupt selection and culling in anytime mode
        wr(pwm_cmp_pkg::OFS_MODE, 32'h5);
        wr(pwm_cmp_pkg::OFS_CULL_OPT, 32'h40);
        // Duty U moved past the count after its up match: next is ignored
        wait_ev(1);
        repeat (12) @(posedge clk_i);
        wr(pwm_cmp_pkg::OFS_DUTY_U, 32'h28);
        d = n_dm;
        win(2 * p2, a, b, c);
        chk_n(a, 0);
        chk_n(b, 2);
        chk_n(n_dm - d, 4);
        wait_ev(1);
        wr(pwm_cmp_pkg::OFS_CULL_OPT, 32'h63);
        // One crest passes first, so the clear has a count to discard
        repeat (60) @(posedge clk_i);
        wr(pwm_cmp_pkg::OFS_CULL_OPT, 32'h63);
        rd(pwm_cmp_pkg::OFS_STATUS, q);
        chk32({27'h0, q[6:2]}, 32'h0);
        win(4 * p2, a, b, c);
        chk_n(c, 2);
        // Intermittent: transfer only where a culled interrupt issues
        wr(pwm_cmp_pkg::OFS_CULL_OPT, 32'h61);
        wr(pwm_cmp_pkg::OFS_MODE, 32'h6);
        wait_ev(2);
        wr(pwm_cmp_pkg::OFS_CYCLE, 32'h20);
        wr(pwm_cmp_pkg::OFS_DUTY_U, 32'h8);
        wait_ev(3);
        repeat (2) @(posedge clk_i);
        chk_n(int'(t_xf - t_irq <= 1 && t_irq - t_xf <= 1), 1);
        chk32({31'h0, bad}, 32'h0);
        finish_test();
    end

    // Whole run needs under two thousand cycles; this is over ten times that
    initial begin
        #(8 * 20000);
        num_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
